// file: ifsb_pkg.sv
// Constants for the interrupt flag status bank
// Functional notes
// - An implemented flag reads 1 once its source has raised a request and 0 if none occurred.
// - Flag word 1 holds comparator at bit 2, I2C one master at bit 1, I2C one slave at bit 0.
// - Flag word 2 holds DMA channel 4 at bit 14, parallel port at bit 13; 15 and 12..5 read 0.
// - Flag word 2 holds DMA 3 at bit 4, CAN event 3, CAN receive 2, SPI two event 1, error 0.
// - Flag word 3 holds PWM one fault A 15, RTC 14, DMA 5 at 13, encoder one 10, PWM one error 9.
// - Flag word 3 bits 12..11 and 8..0 ignore writes and read as zero.
// - Flag word 4 holds DAC left 15, DAC right 14, encoder two 11, PWM two fault A 10, error 9.
// - Flag word 4 holds CAN transmit 6, DMA 7 at 5, DMA 6 at 4, CRC 3, UART two err 2, one err 1.
// - Flag word 4 bits 13..12, 8..7 and 0 read as zero.
// - Without a CAN controller the CAN event, receive and transmit flags never rise.
// - Without an audio DAC the DAC left and right flags never rise.
// - Every implemented flag is software readable and writable and clears at reset.
package ifsb_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] IFSB_OFS_FLAG1 = 8'h00;
  localparam logic [7:0] IFSB_OFS_FLAG2 = 8'h04;
  localparam logic [7:0] IFSB_OFS_FLAG3 = 8'h08;
  localparam logic [7:0] IFSB_OFS_FLAG4 = 8'h0C;
  localparam int IFSB_NUM_REGS = 4;
  // Reset value of every flag word
  localparam logic [15:0] IFSB_FLAG_RST = 16'h0000;
  // Implemented-bit masks per flag word
  localparam logic [15:0] IFSB_MASK1 = 16'h0007;
  localparam logic [15:0] IFSB_MASK2 = 16'h601F;
  localparam logic [15:0] IFSB_MASK3 = 16'hE600;
  localparam logic [15:0] IFSB_MASK4 = 16'hCE7E;
  // Flag word 1 bit positions
  localparam int IFSB_B1_CMP = 2;
  localparam int IFSB_B1_I2C1_MST = 1;
  localparam int IFSB_B1_I2C1_SLV = 0;
  // Flag word 2 bit positions
  localparam int IFSB_B2_DMA4 = 14;
  localparam int IFSB_B2_PPORT = 13;
  localparam int IFSB_B2_DMA3 = 4;
  localparam int IFSB_B2_CAN_EVT = 3;
  localparam int IFSB_B2_CAN_RX = 2;
  localparam int IFSB_B2_SPI2_EVT = 1;
  localparam int IFSB_B2_SPI2_ERR = 0;
  // Flag word 3 bit positions
  localparam int IFSB_B3_PWM1_FLT = 15;
  localparam int IFSB_B3_RTC = 14;
  localparam int IFSB_B3_DMA5 = 13;
  localparam int IFSB_B3_ENC1 = 10;
  localparam int IFSB_B3_PWM1_ERR = 9;
  // Flag word 4 bit positions
  localparam int IFSB_B4_DAC_L = 15;
  localparam int IFSB_B4_DAC_R = 14;
  localparam int IFSB_B4_ENC2 = 11;
  localparam int IFSB_B4_PWM2_FLT = 10;
  localparam int IFSB_B4_PWM2_ERR = 9;
  localparam int IFSB_B4_CAN_TX = 6;
  localparam int IFSB_B4_DMA7 = 5;
  localparam int IFSB_B4_DMA6 = 4;
  localparam int IFSB_B4_CRC = 3;
  localparam int IFSB_B4_UART2_ERR = 2;
  localparam int IFSB_B4_UART1_ERR = 1;
  // Variant masks: bits removed when a peripheral is absent
  localparam logic [15:0] IFSB_CAN2_BITS = 16'h000C;
  localparam logic [15:0] IFSB_CAN4_BITS = 16'h0040;
  localparam logic [15:0] IFSB_DAC4_BITS = 16'hC000;
endpackage

// file: ifsb_flag_if.sv
// Interface between the bus front end and one flag word
`timescale 1ns/100ps
interface ifsb_flag_if;
  logic wr_en;
  logic [1:0] be;
  logic [15:0] wdata;
  logic [15:0] event_set;
  logic [15:0] value;
  modport ctrl (output wr_en, output be, output wdata, output event_set, input value);
  modport word (input wr_en, input be, input wdata, input event_set, output value);
endinterface

// file: ifsb_flag_word.sv
// One 16-bit word of sticky interrupt flags
`timescale 1ns/100ps
module ifsb_flag_word
  import ifsb_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Access from the front end
  ifsb_flag_if.word fw
);
  logic [15:0] flag_q;
  logic [15:0] flag_d;
  logic [15:0] wmask;

  // Next flag value; an event in the clearing cycle still sets the flag
  always_comb
  begin
    wmask = {{8{fw.be[1]}}, {8{fw.be[0]}}} & {16{fw.wr_en}};
    flag_d = (flag_q & ~(wmask & ~fw.wdata)) | (wmask & fw.wdata) | fw.event_set;
    flag_d = flag_d & IMPL_MASK;
  end

  // Flag storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_q <= IFSB_FLAG_RST;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  assign fw.value = flag_q;
endmodule

// file: ifsb_top.sv
// Interrupt flag status bank with a classic Wishbone slave
`timescale 1ns/100ps
module ifsb_top
  import ifsb_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_DAC = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Flag word 1 sources
  input wire logic comparator_req_i,
  input wire logic i2c_one_master_req_i,
  input wire logic i2c_one_slave_req_i,
  // Flag word 2 sources
  input wire logic dma_ch4_done_i,
  input wire logic parallel_port_req_i,
  input wire logic dma_ch3_done_i,
  input wire logic can_event_i,
  input wire logic can_rx_ready_i,
  input wire logic spi_two_event_i,
  input wire logic spi_two_error_i,
  // Flag word 3 sources
  input wire logic pwm_one_fault_a_i,
  input wire logic rtc_event_i,
  input wire logic dma_ch5_done_i,
  input wire logic encoder_one_event_i,
  input wire logic pwm_one_error_i,
  // Flag word 4 sources
  input wire logic dac_left_req_i,
  input wire logic dac_right_req_i,
  input wire logic encoder_two_event_i,
  input wire logic pwm_two_fault_a_i,
  input wire logic pwm_two_error_i,
  input wire logic can_tx_request_i,
  input wire logic dma_ch7_done_i,
  input wire logic dma_ch6_done_i,
  input wire logic crc_gen_i,
  input wire logic uart_two_error_i,
  input wire logic uart_one_error_i,
  // Flag words toward the core
  output logic [15:0] flag_word1_o,
  output logic [15:0] flag_word2_o,
  output logic [15:0] flag_word3_o,
  output logic [15:0] flag_word4_o
);
  // Variant masks remove flags of absent peripherals entirely
  // no CAN flags
  localparam logic [15:0] CAN2_KEEP = HAS_CAN ? 16'hFFFF : ~IFSB_CAN2_BITS;
  localparam logic [15:0] CAN4_KEEP = HAS_CAN ? 16'hFFFF : ~IFSB_CAN4_BITS;
  localparam logic [15:0] DAC4_KEEP = HAS_DAC ? 16'hFFFF : ~IFSB_DAC4_BITS;
  localparam logic [15:0] WORD_MASK [IFSB_NUM_REGS] = '{
    IFSB_MASK1,
    IFSB_MASK2 & CAN2_KEEP,
    IFSB_MASK3,
    IFSB_MASK4 & CAN4_KEEP & DAC4_KEEP
  };

  ifsb_flag_if flag_bus [IFSB_NUM_REGS] ();

  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [IFSB_NUM_REGS-1:0] hit;
  logic [15:0] ev [IFSB_NUM_REGS];
  logic [15:0] val [IFSB_NUM_REGS];

  // Address decode; unmapped offsets answer with zero and drop writes
  always_comb
  begin
    hit = '0;
    case (adr_i)
      IFSB_OFS_FLAG1: hit[0] = 1'b1;
      IFSB_OFS_FLAG2: hit[1] = 1'b1;
      IFSB_OFS_FLAG3: hit[2] = 1'b1;
      IFSB_OFS_FLAG4: hit[3] = 1'b1;
      default: hit = '0;
    endcase
  end

  // Event vectors per flag word
  always_comb
  begin
    ev[0] = '0;
    ev[1] = '0;
    ev[2] = '0;
    ev[3] = '0;
    ev[0][IFSB_B1_CMP] = comparator_req_i;
    ev[0][IFSB_B1_I2C1_MST] = i2c_one_master_req_i;
    ev[0][IFSB_B1_I2C1_SLV] = i2c_one_slave_req_i;
    ev[1][IFSB_B2_DMA4] = dma_ch4_done_i;
    ev[1][IFSB_B2_PPORT] = parallel_port_req_i;
    ev[1][IFSB_B2_DMA3] = dma_ch3_done_i;
    ev[1][IFSB_B2_CAN_EVT] = can_event_i;
    ev[1][IFSB_B2_CAN_RX] = can_rx_ready_i;
    ev[1][IFSB_B2_SPI2_EVT] = spi_two_event_i;
    ev[1][IFSB_B2_SPI2_ERR] = spi_two_error_i;
    ev[2][IFSB_B3_PWM1_FLT] = pwm_one_fault_a_i;
    ev[2][IFSB_B3_RTC] = rtc_event_i;
    ev[2][IFSB_B3_DMA5] = dma_ch5_done_i;
    ev[2][IFSB_B3_ENC1] = encoder_one_event_i;
    ev[2][IFSB_B3_PWM1_ERR] = pwm_one_error_i;
    ev[3][IFSB_B4_DAC_L] = dac_left_req_i;
    ev[3][IFSB_B4_DAC_R] = dac_right_req_i;
    ev[3][IFSB_B4_ENC2] = encoder_two_event_i;
    ev[3][IFSB_B4_PWM2_FLT] = pwm_two_fault_a_i;
    ev[3][IFSB_B4_PWM2_ERR] = pwm_two_error_i;
    ev[3][IFSB_B4_CAN_TX] = can_tx_request_i;
    ev[3][IFSB_B4_DMA7] = dma_ch7_done_i;
    ev[3][IFSB_B4_DMA6] = dma_ch6_done_i;
    ev[3][IFSB_B4_CRC] = crc_gen_i;
    ev[3][IFSB_B4_UART2_ERR] = uart_two_error_i;
    ev[3][IFSB_B4_UART1_ERR] = uart_one_error_i;
  end

  // One flag word per register; the write lands on the ack edge only
  genvar g;
  generate
    for (g = 0; g < IFSB_NUM_REGS; g++)
    begin : g_word
      assign flag_bus[g].wr_en = cyc_i & stb_i & we_i & ack_q & hit[g];
      assign flag_bus[g].be = sel_i[1:0];
      assign flag_bus[g].wdata = dat_i[15:0];
      assign flag_bus[g].event_set = ev[g];
      assign val[g] = flag_bus[g].value;
      ifsb_flag_word #(
        .IMPL_MASK(WORD_MASK[g])
      ) u_word (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fw(flag_bus[g].word)
      );
    end
  endgenerate

  // Ack one cycle after the request, dropped the cycle after
  always_comb
  begin
    ack_d = cyc_i & stb_i & ~ack_q;
    rdata_d = rdata_q;
    if (ack_d)
    begin
      rdata_d = 32'h0000_0000;
      for (int i = 0; i < IFSB_NUM_REGS; i++)
      begin
        if (hit[i])
        begin
          rdata_d = {16'h0000, val[i]};
        end
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from registers
  assign ack_o = ack_q;
  assign dat_o = rdata_q;
  assign flag_word1_o = val[0];
  assign flag_word2_o = val[1];
  assign flag_word3_o = val[2];
  assign flag_word4_o = val[3];
endmodule

// file: ifsb_properties.sv
// Port-level assertions for the interrupt flag status bank
`timescale 1ns/100ps
module ifsb_properties
  import ifsb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Flag words
  input wire logic [15:0] flag_word1_o,
  input wire logic [15:0] flag_word2_o,
  input wire logic [15:0] flag_word3_o,
  input wire logic [15:0] flag_word4_o,
  // One event source, for the set-beats-clear check
  input wire logic crc_gen_i
);
  // All four words side by side
  wire [63:0] all_f = {flag_word4_o, flag_word3_o, flag_word2_o, flag_word1_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // One registered answer per request
  ack_pulse_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle");
  // Unimplemented positions of words 2 to 4 never set
  word2_hole_a: assert property ((flag_word2_o & ~IFSB_MASK2) == 16'h0000)
    else $error("word 2 hole set");
  word3_hole_a: assert property ((flag_word3_o & ~IFSB_MASK3) == 16'h0000)
    else $error("word 3 hole set");
  word4_hole_a: assert property ((flag_word4_o & ~IFSB_MASK4) == 16'h0000)
    else $error("word 4 hole set");
  // Nothing left over from before reset
  reset_clear_a: assert property ($fell(rst_i) |-> all_f == '0 && !ack_o)
    else $error("flags not cleared by reset");
  // Only a bus write may clear a flag, so no request is lost
  sticky_hold_a:
    assert property (!(ack_o && we_i) |=> (all_f & $past(all_f)) == $past(all_f))
    else $error("flag cleared without write");
  // Writing ones sets the written flags
  write_sets_a:
    assert property (ack_o && we_i && adr_i == IFSB_OFS_FLAG3 && sel_i[1:0] == 2'b11
      |=> (flag_word3_o & $past(dat_i[15:0])) == ($past(dat_i[15:0]) & IFSB_MASK3))
    else $error("written ones not set");
  // Read returns the word as it stood at the request
  read_data_a:
    assert property (ack_o && !we_i && adr_i == IFSB_OFS_FLAG2
      |-> dat_o == {16'h0000, $past(flag_word2_o)})
    else $error("read data wrong");
  // Holes in the map read as zero
  unmapped_a: assert property (ack_o && !we_i && adr_i > IFSB_OFS_FLAG4 |-> dat_o == '0)
    else $error("unmapped read not zero");
  // An event always lands, even on the edge of a clearing write
  event_sets_a: assert property (crc_gen_i |=> flag_word4_o[IFSB_B4_CRC])
    else $error("event did not set its flag");
  // Main scenarios reached
  cover property (ack_o && we_i);
  cover property (crc_gen_i && ack_o && we_i && adr_i == IFSB_OFS_FLAG4);
  cover property (ack_o && !we_i && adr_i == IFSB_OFS_FLAG4);
  cover property ($rose(flag_word4_o[IFSB_B4_CRC]));
endmodule

// file: ifsb_src_model.sv
// Peripheral event source model: one-cycle request pulses
`timescale 1ns/100ps
module ifsb_src_model
(
  // Clock
  input wire logic clk_i,
  // Requests from the bench, one bit per flag position
  input wire logic [63:0] req_i,
  // Event lines to the flag bank
  output logic [63:0] ev_o
);
  // Registered so events leave on a clean edge, as a real peripheral does
  always_ff @(posedge clk_i)
    ev_o <= req_i;
endmodule

// file: ifsb_top_test.sv
// Self-checking bench for the interrupt flag status bank
`timescale 1ns/100ps
module ifsb_top_test;
  import ifsb_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = '0, got;
  logic [63:0] req = '0, ev;
  wire [63:0] fw [2];
  wire [31:0] rd [2];
  wire [1:0] ack;
  int errors = 0, samples_checked = 0, cycles = 0;
  localparam logic [63:0] MASK = {IFSB_MASK4, IFSB_MASK3, IFSB_MASK2, IFSB_MASK1};
  localparam logic [63:0] GONE = {IFSB_DAC4_BITS | IFSB_CAN4_BITS, 16'h0000, IFSB_CAN2_BITS, 16'h0000};
  // Flags that the part without CAN and DAC still carries
  localparam logic [63:0] KEEP = MASK & ~GONE;
  ifsb_src_model src (.clk_i(clk_i), .req_i(req), .ev_o(ev));
  // Full part and a part without CAN and DAC, on the same bus and events
  for (genvar g = 0; g < 2; g++)
  begin : g_d
    ifsb_top #(.HAS_CAN(g == 0), .HAS_DAC(g == 0)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
      .dat_o(rd[g]), .ack_o(ack[g]), .comparator_req_i(ev[2]),
      .i2c_one_master_req_i(ev[1]), .i2c_one_slave_req_i(ev[0]), .dma_ch4_done_i(ev[30]),
      .parallel_port_req_i(ev[29]), .dma_ch3_done_i(ev[20]), .can_event_i(ev[19]),
      .can_rx_ready_i(ev[18]), .spi_two_event_i(ev[17]), .spi_two_error_i(ev[16]),
      .pwm_one_fault_a_i(ev[47]), .rtc_event_i(ev[46]), .dma_ch5_done_i(ev[45]),
      .encoder_one_event_i(ev[42]), .pwm_one_error_i(ev[41]), .dac_left_req_i(ev[63]),
      .dac_right_req_i(ev[62]), .encoder_two_event_i(ev[59]), .pwm_two_fault_a_i(ev[58]),
      .pwm_two_error_i(ev[57]), .can_tx_request_i(ev[54]), .dma_ch7_done_i(ev[53]),
      .dma_ch6_done_i(ev[52]), .crc_gen_i(ev[51]), .uart_two_error_i(ev[50]),
      .uart_one_error_i(ev[49]), .flag_word1_o(fw[g][15:0]), .flag_word2_o(fw[g][31:16]),
      .flag_word3_o(fw[g][47:32]), .flag_word4_o(fw[g][63:48]));
  end
  // Free-running clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard: the whole run needs well under this
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; waits for ack, the guard bounds it
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {2'b00, s};
    dat <= {16'h0000, d};
    do
      @(posedge clk_i);
    while (ack[0] !== 1'b1);
    got = rd[0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic t_reset();
    for (int w = 0; w < 5; w++)
    begin
      bus(1'b0, 8'(w * 4), 16'h0000, 2'b11);
      chk("reset read", got, '0);
    end
  endtask
  // Walk one event at a time and clear it by software
  task automatic t_walk();
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clk_i);
      req <= 64'h0000_0000_0000_0001 << i;
      @(posedge clk_i);
      req <= '0;
      repeat (2) @(posedge clk_i);
      chk("flag map", fw[0], MASK & (64'h0000_0000_0000_0001 << i));
      chk("no can", fw[1] & GONE & ~{IFSB_DAC4_BITS, 48'h0}, '0);
      chk("no dac", fw[1] & {IFSB_DAC4_BITS, 48'h0}, '0);
      chk("variant map", fw[1], KEEP & (64'h0000_0000_0000_0001 << i));
      for (int w = 0; w < 4; w++)
        bus(1'b1, 8'(w * 4), 16'h0000, 2'b11);
      // The last clear lands on the edge the task returns on; look once it has settled
      @(posedge clk_i);
      chk("cleared", fw[0], '0);
      chk("variant cleared", fw[1], '0);
    end
  endtask
  // Event pulse timed onto the ack edge of a clearing write: the set must win
  task automatic t_race();
    fork
      bus(1'b1, IFSB_OFS_FLAG4, 16'h0000, 2'b11);
      begin
        @(posedge clk_i);
        req <= 64'h0000_0000_0000_0001 << (48 + IFSB_B4_CRC);
        @(posedge clk_i);
        req <= '0;
      end
    join
    @(posedge clk_i);
    chk("set wins", fw[0], 64'h0000_0000_0000_0001 << (48 + IFSB_B4_CRC));
    chk("variant set wins", fw[1], 64'h0000_0000_0000_0001 << (48 + IFSB_B4_CRC));
    bus(1'b1, IFSB_OFS_FLAG4, 16'h0000, 2'b11);
    @(posedge clk_i);
    chk("race cleared", fw[0], '0);
  endtask
  // Write all ones, then clear only the low byte lane
  task automatic t_rw();
    for (int w = 0; w < 4; w++)
    begin
      bus(1'b1, 8'(w * 4), 16'hFFFF, 2'b11);
      bus(1'b0, 8'(w * 4), 16'h0000, 2'b00);
      chk("write ones", got, {16'h0000, MASK[w * 16 +: 16]});
      chk("variant ones", rd[1], {16'h0000, KEEP[w * 16 +: 16]});
      bus(1'b1, 8'(w * 4), 16'h0000, 2'b01);
      bus(1'b0, 8'(w * 4), 16'h0000, 2'b00);
      chk("lane clear", got, {16'h0000, MASK[w * 16 +: 16] & 16'hFF00});
      chk("variant lane", rd[1], {16'h0000, KEEP[w * 16 +: 16] & 16'hFF00});
    end
    // Words 2 to 4 are now nonzero, so a hole that leaked stale data would show
    bus(1'b0, 8'h10, 16'h0000, 2'b11);
    chk("unmapped read", got, '0);
  endtask
  task automatic end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_walk();
    t_race();
    t_rw();
    end_sim();
  end
endmodule
bind ifsb_top ifsb_properties props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .flag_word1_o(flag_word1_o), .flag_word2_o(flag_word2_o),
  .flag_word3_o(flag_word3_o), .flag_word4_o(flag_word4_o), .crc_gen_i(crc_gen_i));
